// ### rtl/fts_supervisor.sv
// frame timing supervisor: transmit scheduling and receive supervision
`timescale 1ns/10ps
module fts_supervisor
  import fts_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic           ref_clk,
  input  wire logic           nrst,
  input  wire fts_tx_cfg_t    tx_cfg,
  input  wire fts_rx_cfg_t    rx_cfg,
  input  wire logic           sw_in,
  input  wire logic           app_change,
  input  wire logic [DW-1:0]  tx_value,
  input  wire logic           tx_done,
  input  wire logic           rx_valid,
  input  wire logic [DW-1:0]  rx_data,
  input  wire logic           clr_late,
  output logic                tx_req,
  output logic [DW-1:0]       tx_data,
  output logic [DW-1:0]       rx_signal,
  output logic                comm_fail,
  output logic                rx_seen,
  output logic [DW-1:0]       act_out,
  output logic                cfg_bad,
  output logic [NLAT-1:0]     late
);
  logic            tick;
  fts_tx_state_t   tx_st;
  fts_rx_state_t   rx_st;
  logic [TW-1:0]   per_cnt;
  logic [TW-1:0]   upd_cnt;
  logic [TW-1:0]   sup_cnt;
  logic            ev_pend;
  logic            sw_prev;

  fts_tick #(.CYCLES(TICK_CYC)) u_tick (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tick    (tick)
  );

  // transmit decision, all combinational
  wire             in_change = (sw_in != sw_prev);
  wire             ev_now    = in_change | app_change;
  wire [TW:0]      per_next  = {1'b0, per_cnt} + 17'h00001;
  // one tick early is allowed: tick phase against launch is unknown
  wire             per_due   = (per_next >= {1'b0, tx_cfg.period});
  // strictly above the setting: the first tick may land one cycle after launch;
  // a saturated count also counts as expired so a maximum setting cannot lock the sender
  wire             upd_ok    = (upd_cnt > tx_cfg.update) | (upd_cnt == CNT_MAX);
  wire             tx_idle   = (tx_st == FTS_TX_IDLE);
  wire             launch    = tx_idle & upd_ok & (per_due | ev_pend | ev_now);
  wire [TW-1:0]    per_inc   = (per_cnt == CNT_MAX) ? per_cnt : per_cnt + 1'b1;
  wire [TW-1:0]    upd_inc   = (upd_cnt == CNT_MAX) ? upd_cnt : upd_cnt + 1'b1;
  // set wins over clear so an event in the launch cycle still gets a send
  wire             next_ev_pend = ev_now | (ev_pend & ~launch);

  // transmit state and request handshake
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_st   <= FTS_TX_IDLE;
      tx_req  <= 1'b0;
      tx_data <= DATA_RESET;
      per_cnt <= CNT_RESET;
      upd_cnt <= CNT_RESET;
      ev_pend <= 1'b0;
      sw_prev <= 1'b0;
    end else begin
      sw_prev <= sw_in;
      ev_pend <= next_ev_pend;
      unique case (tx_st)
        FTS_TX_IDLE: begin
          if (launch) begin
            tx_st   <= FTS_TX_BUSY;
            tx_req  <= 1'b1;
            tx_data <= tx_value;
          end
        end
        FTS_TX_BUSY: begin
          if (tx_done) begin
            tx_st  <= FTS_TX_IDLE;
            tx_req <= 1'b0;
          end
        end
      endcase
      // both timers restart at launch; update time spans start to start
      if (launch) begin
        per_cnt <= '0;
        upd_cnt <= '0;
      end else if (tick) begin
        per_cnt <= per_inc;
        upd_cnt <= upd_inc;
      end
    end
  end

  // cycles since the last launch, kept only so the checks can measure real spacing
  logic [47:0] gap_cyc;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gap_cyc <= '1;
    end else if (launch) begin
      gap_cyc <= 48'h000000000001;
    end else if (gap_cyc != '1) begin
      gap_cyc <= gap_cyc + 1'b1;
    end
  end

  // latency monitors: one for the switch input, one for internal decisions
  wire [NLAT-1:0] lat_start = {app_change, in_change};
  wire [TW-1:0]   lat_budget [NLAT];
  assign lat_budget[LAT_INPUT] = tx_cfg.in_delay;
  assign lat_budget[LAT_DATA]  = tx_cfg.data_delay;

  genvar gi;
  generate
    for (gi = 0; gi < NLAT; gi++) begin : g_lat
      logic          run;
      logic          sent;
      logic [TW-1:0] cnt;
      // only a frame launched after the change may close the window
      wire           done_ok = tx_done & sent;
      wire           over    = run & (cnt > lat_budget[gi]);
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          run          <= 1'b0;
          sent         <= 1'b0;
          cnt          <= '0;
          late[gi]     <= 1'b0;
        end else begin
          if (lat_start[gi] && !run) begin
            run  <= 1'b1;
            sent <= 1'b0;
            cnt  <= '0;
          end else begin
            if (done_ok) run <= 1'b0;
            if (launch && run) sent <= 1'b1;
            if (tick && run && cnt != CNT_MAX) cnt <= cnt + 1'b1;
          end
          late[gi] <= over | (late[gi] & ~clr_late);
        end
      end
    end
  endgenerate

  // receive supervision; invalid timeouts are clamped to just above 2x period
  wire [TW:0]   two_per   = {rx_cfg.period, 1'b0};
  wire          to_bad    = ({1'b0, rx_cfg.timeout} <= two_per);
  wire [TW:0]   eff_to    = to_bad ? two_per + 17'h00001 : {1'b0, rx_cfg.timeout};
  wire          sup_exp   = ({1'b0, sup_cnt} >= eff_to);
  wire [TW-1:0] sup_inc   = (sup_cnt == CNT_MAX) ? sup_cnt : sup_cnt + 1'b1;
  wire          go_fail   = (rx_st == FTS_RX_LIVE) & tick & sup_exp & ~rx_valid;

  // a reception in the timeout cycle wins, so no false failure is shown
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_st     <= FTS_RX_INIT;
      sup_cnt   <= '0;
      comm_fail <= 1'b0;
      rx_seen   <= 1'b0;
      rx_signal <= DATA_RESET;
      act_out   <= DATA_RESET;
      cfg_bad   <= 1'b0;
    end else begin
      cfg_bad <= to_bad;
      if (rx_valid) begin
        rx_st     <= FTS_RX_LIVE;
        sup_cnt   <= '0;
        comm_fail <= 1'b0;
        rx_seen   <= 1'b1;
        rx_signal <= rx_data;
        act_out   <= rx_data;
      end else begin
        if (tick && rx_st != FTS_RX_INIT) sup_cnt <= sup_inc;
        if (go_fail) begin
          rx_st     <= FTS_RX_FAIL;
          comm_fail <= 1'b1;
        end
        unique case (rx_st)
          FTS_RX_INIT: rx_signal <= rx_cfg.default_val;
          FTS_RX_LIVE: rx_signal <= go_fail ? rx_cfg.fail_value : rx_signal;
          FTS_RX_FAIL: rx_signal <= rx_cfg.fail_value;
          default:     rx_signal <= rx_cfg.fail_value;
        endcase
      end
    end
  end

  // checks
  a_update_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
    launch |-> gap_cyc >= 48'(tx_cfg.update) * 48'(TICK_CYC))
    else $error("send inside update time");
  a_period_send: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tx_idle && upd_ok && per_due) |=> tx_req) else $error("periodic send missed");
  a_early_bound: assert property (@(posedge ref_clk) disable iff (!nrst)
    (launch && !ev_pend && !ev_now && gap_cyc != '1)
    |-> gap_cyc + 48'(2 * TICK_CYC) > 48'(tx_cfg.period) * 48'(TICK_CYC))
    else $error("periodic send too early");
  a_event_held: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ev_now && !launch) |=> ev_pend) else $error("event dropped");
  a_req_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tx_req && !tx_done) |=> tx_req && $stable(tx_data)) else $error("request dropped");
  a_data_exact: assert property (@(posedge ref_clk) disable iff (!nrst)
    launch |=> tx_data == $past(tx_value)) else $error("sent value differs");
  a_timeout_fail: assert property (@(posedge ref_clk) disable iff (!nrst)
    go_fail |=> comm_fail && rx_signal == $past(rx_cfg.fail_value))
    else $error("timeout not flagged");
  a_fail_value: assert property (@(posedge ref_clk) disable iff (!nrst)
    (comm_fail && !rx_valid) |=> comm_fail && rx_signal == $past(rx_cfg.fail_value))
    else $error("stale data during failure");
  a_power_default: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!rx_seen && !rx_valid) |=> !rx_seen && rx_signal == $past(rx_cfg.default_val))
    else $error("default not shown");
  a_rx_restart: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_valid |=> !comm_fail && rx_signal == $past(rx_data) && sup_cnt == 0)
    else $error("reception not taken");
  a_actuate: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_valid |=> act_out == $past(rx_data)) else $error("output not actuated");
  a_cfg_check: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 cfg_bad == ($past(rx_cfg.timeout) <= {$past(rx_cfg.period), 1'b0}))
    else $error("timeout check wrong");
  a_late_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
    (g_lat[LAT_INPUT].over) |=> late[LAT_INPUT]) else $error("input latency miss");

  c_event_defer: cover property (@(posedge ref_clk) disable iff (!nrst)
    (ev_now && !upd_ok) ##[1:1000] launch);
  c_periodic: cover property (@(posedge ref_clk) disable iff (!nrst)
    (launch && !ev_pend && !ev_now));
  c_failure: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(comm_fail));
  c_recover: cover property (@(posedge ref_clk) disable iff (!nrst)
    comm_fail ##1 rx_valid);
endmodule : fts_supervisor

// ### rtl/fts_pkg.sv
// package: constants and carriers for the frame timing supervisor
package fts_pkg;
  localparam int          CLK_PERIOD_NS = 10;     // ref_clk period
  localparam int          TICK_US       = 1000;   // time base of every timer
  localparam int          TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int          TW            = 16;     // timer width in bits, counts ticks
  localparam int          DW            = 16;     // signal width
  localparam int          NLAT          = 2;      // latency monitors
  localparam int          LAT_INPUT     = 0;      // monitor for input changes
  localparam int          LAT_DATA      = 1;      // monitor for internal decisions
  localparam logic [TW-1:0] CNT_RESET   = 16'hFFFF; // counters start expired
  localparam logic [TW-1:0] CNT_MAX     = 16'hFFFF;
  localparam logic [DW-1:0] DATA_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    FTS_TX_IDLE = 2'b00,
    FTS_TX_BUSY = 2'b01
  } fts_tx_state_t;

  typedef enum logic [1:0] {
    FTS_RX_INIT = 2'b00,
    FTS_RX_LIVE = 2'b01,
    FTS_RX_FAIL = 2'b11
  } fts_rx_state_t;

  typedef struct packed {
    logic [TW-1:0] period;      // periodic interval, ticks
    logic [TW-1:0] update;      // update time, ticks
    logic [TW-1:0] in_delay;    // input delay budget, ticks
    logic [TW-1:0] data_delay;  // data delay budget, ticks
  } fts_tx_cfg_t;

  typedef struct packed {
    logic [TW-1:0] period;      // periodic interval of the watched frame
    logic [TW-1:0] timeout;     // supervision timeout, ticks
    logic [DW-1:0] fail_value;  // substitute on communication failure
    logic [DW-1:0] default_val; // shown until first reception
  } fts_rx_cfg_t;
endpackage : fts_pkg

// ### rtl/fts_tick.sv
// time base: one-cycle tick enable every CYCLES clocks
`timescale 1ns/10ps
module fts_tick #(
  parameter int CYCLES = 100000
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  output logic      tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;
  wire           wrap = (cnt == LAST);

  // free-running divider, tick is registered so it is glitch free
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? '0 : cnt + 1'b1;
      tick <= wrap;
    end
  end
endmodule : fts_tick

// ### tb/fts_bus_model.sv
// bus-side partner: completes each requested frame after a set number of cycles
`timescale 1ns/10ps
module fts_bus_model (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] lat,
  input  wire logic       tx_req,
  output logic            tx_done
);
  logic [7:0] cnt;

  // a slow bus (large lat) stretches the frame, as arbitration losses would
  always_ff @(posedge ref_clk) begin
    if (!nrst || !tx_req || tx_done) begin
      cnt     <= 8'h00;
      tx_done <= 1'b0;
    end else begin
      cnt     <= cnt + 8'h01;
      tx_done <= (cnt + 8'h01 >= lat);  // one-cycle pulse, only while requested
    end
  end
endmodule : fts_bus_model

// ### tb/tb_top.sv
// self-checking bench for the frame timing supervisor
`timescale 1ns/10ps
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t %s", $time, m); end end
module tb_top;
  import fts_pkg::*;
  localparam int T = 10;  // clocks per tick, kept small so timeouts stay short
  localparam int PER = 10, UPD = 4, TO = 5;
  logic ref_clk, nrst, sw_in, app_change, tx_done, rx_valid, clr_late;
  logic tx_req, comm_fail, rx_seen, cfg_bad, prq;
  logic [DW-1:0] tx_value, rx_data, tx_data, rx_signal, act_out, pv;
  logic [NLAT-1:0] late;
  logic [7:0] lat;
  fts_tx_cfg_t tx_cfg;
  fts_rx_cfg_t rx_cfg;
  int err_count, n_compared, cyc, lt, nl, k, n0;

  fts_supervisor #(.TICK_CYC(T)) DUT (.ref_clk(ref_clk), .nrst(nrst), .tx_cfg(tx_cfg),
    .rx_cfg(rx_cfg), .sw_in(sw_in), .app_change(app_change), .tx_value(tx_value),
    .tx_done(tx_done), .rx_valid(rx_valid), .rx_data(rx_data), .clr_late(clr_late),
    .tx_req(tx_req), .tx_data(tx_data), .rx_signal(rx_signal), .comm_fail(comm_fail),
    .rx_seen(rx_seen), .act_out(act_out), .cfg_bad(cfg_bad), .late(late));
  fts_bus_model bus (.ref_clk(ref_clk), .nrst(nrst), .lat(lat), .tx_req(tx_req),
    .tx_done(tx_done));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic end_sim;
    $display("errors %0d, comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // one received frame; outputs follow on the next cycle; more keeps the strobe up
  task automatic rx_frame(input logic [DW-1:0] d, input logic more);
    rx_valid = 1'b1;
    rx_data  = d;
    step(1);
    if (!more) begin
      rx_valid = 1'b0;
      rx_data  = ~d;  // stale bus data must not leak through
    end
    `CHK(rx_signal, d, "rx_signal after frame")
    `CHK(act_out, d, "act_out after frame")
    `CHK(comm_fail, 1'b0, "failure after frame")
  endtask : rx_frame

  // wait for the next launch, k counts cycles waited; always moves past the current one
  task automatic wait_launch(input int lim);
    step(1);
    k = 1;
    while (!(tx_req && !prq) && k < lim) begin
      step(1);
      k++;
    end
  endtask : wait_launch

  // launch monitor: data taken at launch, spacing between launches
  always @(posedge ref_clk) begin
    if (tx_req && !prq) begin
      `CHK(tx_data, pv, "tx_data differs from launch value")
      if (nl > 0 && cyc - lt < UPD * T) `CHK(0, 1, "launches too close")
      if (nl > 0 && cyc - lt > (PER + 1) * T) `CHK(0, 1, "periodic launch late")
      lt = cyc;
      nl++;
    end
    prq = tx_req;
    pv  = tx_value;
    cyc++;
  end

  // watchdog: the whole sequence needs at most about 1140 cycles
  initial begin
    #200us;
    err_count++;
    end_sim();
  end

  initial begin
    {err_count, n_compared, cyc, lt, nl, prq} = '0;
    nrst = 1'b0; sw_in = 1'b0; app_change = 1'b0; rx_valid = 1'b0; clr_late = 1'b0;
    rx_data = 16'h0000; tx_value = 16'h1234; lat = 8'h05; pv = 16'h0000;
    tx_cfg = '{period: 16'h000A, update: 16'h0004, in_delay: 16'h0008, data_delay: 16'h0000};
    rx_cfg = '{period: 16'h0002, timeout: 16'h0005, fail_value: 16'hFA11,
               default_val: 16'h5A5A};
    step(2);
    nrst = 1'b1;
    step(2);
    `CHK(rx_signal, 16'h5A5A, "power-up default")
    step(3 * TO * T);
    `CHK(comm_fail, 1'b0, "failure before first frame")
    `CHK(cfg_bad, 1'b0, "valid timeout flagged")
    rx_cfg.timeout = 16'h0004;  // exactly twice the period: invalid
    step(3);
    `CHK(cfg_bad, 1'b1, "timeout at bound accepted")
    rx_cfg.timeout = 16'h0005;
    step(3);
    `CHK(cfg_bad, 1'b0, "valid timeout flagged")
    rx_frame(16'hC0DE, 1'b1);
    `CHK(rx_seen, 1'b1, "first frame not seen")
    rx_frame(16'h0BAD, 1'b0);  // back to back
    k = 0;
    while (comm_fail !== 1'b1 && k < (TO + 2) * T) begin
      step(1);
      k++;
    end
    `CHK(k >= TO * T && k <= (TO + 1) * T + 2, 1'b1, "failure timing")
    `CHK(rx_signal, 16'hFA11, "failure substitute")
    rx_frame(16'h7777, 1'b0);  // recovery
    // event just after a launch must be deferred, not dropped
    wait_launch(2 * PER * T);
    tx_value = 16'hA5A5;
    step(1);
    sw_in = 1'b1;
    step(1);
    wait_launch((UPD + 2) * T);
    `CHK(k < (UPD + 2) * T, 1'b1, "deferred event never sent")
    wait_launch(2 * PER * T);
    `CHK(late[LAT_INPUT], 1'b0, "input delay exceeded")
    // internal decision over a slow bus with zero data budget
    lat = 8'h1E;
    step(UPD * T);
    tx_value = 16'h3C3C;
    app_change = 1'b1;
    step(1);
    app_change = 1'b0;
    step((UPD + 6) * T);
    `CHK(late[LAT_DATA], 1'b1, "data delay miss not flagged")
    clr_late = 1'b1;
    step(1);
    clr_late = 1'b0;
    step(1);
    `CHK(late, 2'b00, "late not cleared")
    lat = 8'h05;
    n0  = nl;
    step(3 * PER * T);  // let the periodic schedule run under the monitor
    `CHK(nl - n0 >= 3, 1'b1, "periodic schedule stalled")
    end_sim();
  end
endmodule : tb_top
